//--- inc/wdpc_pkg.sv
/*
 * Package for the watchdog period control block: register map, field
 * layout, reset values and period codes.
 * Assumes an 8-bit register port and a single 20 MHz clock.
 */
package wdpc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] WDPC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] WDPC_ADDR_STATUS = 4'h1;

    // ****************************************
    // Field layout of the control register
    // ****************************************
    localparam int WDPC_RUN_BIT = 0;
    localparam int WDPC_PS_LSB = 1;
    localparam int WDPC_PS_MSB = 5;

    // ****************************************
    // Reset values and period codes
    // ****************************************
    localparam logic [4:0] WDPC_PS_RESET = 5'h0B;
    localparam logic WDPC_RUN_RESET = 1'b0;
    localparam logic [4:0] WDPC_PS_MAX = 5'h12;
    localparam logic [4:0] WDPC_PS_MIN = 5'h00;
    localparam int WDPC_BASE_LOG2 = 5;
    localparam int WDPC_CNT_W = 23;

    // Enable setting held outside the register
    typedef enum logic [1:0] {
        WDPC_EN_OFF = 2'b00,
        WDPC_EN_SW = 2'b01,
        WDPC_EN_ON_SLEEP_OFF = 2'b10,
        WDPC_EN_ON = 2'b11
    } wdpc_en_t;

    // Timer state, Gray along idle -> counting -> expired
    typedef enum logic [1:0] {
        WDPC_ST_IDLE = 2'b00,
        WDPC_ST_COUNT = 2'b01,
        WDPC_ST_EXPIRE = 2'b11
    } wdpc_state_t;

endpackage

//--- inc/wdpc_tick_if.sv
/*
 * Interface carrying the period settings from the register file to the
 * prescale counter, and the timeout back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface wdpc_tick_if;
    logic run;
    logic clear;
    logic [4:0] period;
    logic timeout;

    modport ctrl (output run, output clear, output period, input timeout);
    modport cnt (input run, input clear, input period, output timeout);
endinterface

//--- logic/wdpc_prescaler.sv
/*
 * Prescale counter: counts clock source ticks and pulses timeout when the
 * selected ratio has elapsed.
 * Assumes period codes arrive already mapped to the legal range.
 */
`timescale 1ns/100ps
module wdpc_prescaler
    import wdpc_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic src_tick_i, // Low-frequency source tick
    wdpc_tick_if.cnt tick // Settings in, timeout out
);

    // ****************************************
    // Terminal count
    // ****************************************
    logic [WDPC_CNT_W-1:0] cnt_q;
    logic [WDPC_CNT_W-1:0] last_w;

    // Ratio is 2^(5+code); last count is ratio minus one
    assign last_w = WDPC_CNT_W'((24'h00_0001 << (WDPC_BASE_LOG2
                    + int'(tick.period))) - 24'h00_0001);

    // Counter restarts on clear or when stopped
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i || tick.clear || !tick.run) begin
            cnt_q <= '0;
        end else if (src_tick_i) begin
            cnt_q <= (cnt_q >= last_w) ? '0 : cnt_q + 1'b1;
        end
    end

    // One-cycle timeout pulse at the end of each interval
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            tick.timeout <= 1'b0;
        end else begin
            tick.timeout <= tick.run && !tick.clear && src_tick_i
                            && (cnt_q >= last_w);
        end
    end

endmodule

//--- logic/wdpc_top.sv
/*
 * Watchdog period control: control register, enable decode and the
 * timer state that the register steers.
 * Assumes a plain register port with read data one cycle after the strobe.
 */
// The strobed register port and the register addresses are this design's own decisions.
// Notes on behaviour
// - Period code 0 gives 1:32, each step doubles, up to code 10010.
// - Codes 10011 to 11111 act as the shortest 1:32 interval.
// - Reset loads period code 01011 and clears the software run bit.
// - Top two control bits read zero and ignore writes.
`timescale 1ns/100ps
module wdpc_top
    import wdpc_pkg::*;
(
    input wire logic sys_clk_i, // 20 MHz clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic [3:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, one cycle after strobe
    input wire logic [1:0] config_enable_setting_i, // External enable setting
    input wire logic sleep_i, // Core is asleep
    input wire logic src_tick_i, // Low-frequency source tick
    input wire logic kick_i, // Clear-watchdog pulse
    output logic wdt_running_o, // Timer is counting
    output logic wdt_timeout_o // Timeout pulse
);

    // ****************************************
    // Control register
    // ****************************************
    logic [4:0] period_select_q;
    logic software_run_bit_q;
    logic wr_ctrl_w;

    assign wr_ctrl_w = wr_i && (addr_i == WDPC_ADDR_CONTROL);

    // Period select field, loaded with its reset pattern
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            period_select_q <= WDPC_PS_RESET;
        end else if (wr_ctrl_w) begin
            period_select_q <= wdata_i[WDPC_PS_MSB:WDPC_PS_LSB];
        end
    end

    // Software run bit; bits 7:6 of the write are dropped
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            software_run_bit_q <= WDPC_RUN_RESET;
        end else if (wr_ctrl_w) begin
            software_run_bit_q <= wdata_i[WDPC_RUN_BIT];
        end
    end

    // ****************************************
    // Enable decode and period mapping
    // ****************************************
    logic run_w;
    logic [4:0] period_eff_w;
    wdpc_en_t en_w;

    assign en_w = wdpc_en_t'(config_enable_setting_i);

    // Run bit only counts in the software-enable setting
    always_comb begin
        case (en_w)
            WDPC_EN_OFF: run_w = 1'b0;
            WDPC_EN_SW: run_w = software_run_bit_q;
            WDPC_EN_ON_SLEEP_OFF: run_w = !sleep_i;
            WDPC_EN_ON: run_w = 1'b1;
            default: run_w = 1'b0;
        endcase
    end

    // Reserved codes fall back to the shortest interval
    assign period_eff_w = (period_select_q > WDPC_PS_MAX) ?
                          WDPC_PS_MIN : period_select_q;

    // ****************************************
    // Prescale counter
    // ****************************************
    wdpc_tick_if tick_if ();

    assign tick_if.run = run_w;
    assign tick_if.period = period_eff_w;
    // Changing the period or kicking restarts the interval
    assign tick_if.clear = kick_i || wr_ctrl_w;

    wdpc_prescaler u_prescaler (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .src_tick_i(src_tick_i),
        .tick(tick_if.cnt)
    );

    // ****************************************
    // Timer state
    // ****************************************
    wdpc_state_t state_q;

    // Idle until enabled, expire on timeout, back to count after
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_q <= WDPC_ST_IDLE;
        end else begin
            case (state_q)
                WDPC_ST_IDLE: begin
                    if (run_w) state_q <= WDPC_ST_COUNT;
                end
                WDPC_ST_COUNT: begin
                    if (!run_w) state_q <= WDPC_ST_IDLE;
                    else if (tick_if.timeout) state_q <= WDPC_ST_EXPIRE;
                end
                WDPC_ST_EXPIRE: begin
                    state_q <= run_w ? WDPC_ST_COUNT : WDPC_ST_IDLE;
                end
                default: state_q <= WDPC_ST_IDLE;
            endcase
        end
    end

    // Registered status outputs
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wdt_running_o <= 1'b0;
            wdt_timeout_o <= 1'b0;
        end else begin
            wdt_running_o <= run_w;
            wdt_timeout_o <= tick_if.timeout;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                WDPC_ADDR_CONTROL: rdata_o <= {2'b00, period_select_q,
                                               software_run_bit_q};
                WDPC_ADDR_STATUS: rdata_o <= {4'h0, config_enable_setting_i,
                                              state_q == WDPC_ST_EXPIRE,
                                              run_w};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

//--- testbench/wdpc_monitor.sv
/* Checker for wdpc_top: reads, enable decode, timeout pulse.
   Assumes binding to wdpc_top and sight of its ports only. */
`timescale 1ns/100ps
module wdpc_monitor
    import wdpc_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic reset_n_i, // Reset, active low
    input wire logic [3:0] addr_i, // Register address
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic [1:0] config_enable_setting_i, // Enable setting
    input wire logic wdt_running_o, // Timer counting
    input wire logic wdt_timeout_o // Timeout pulse
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Control reads show zero in the two top bits
    property p_top_zero;
        rd_i && addr_i == WDPC_ADDR_CONTROL |=> rdata_o[7:6] == 2'b00;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("top control bits not zero");
    // Read data and running flag idle on leaving reset
    property p_reset_idle;
        $rose(reset_n_i) |-> rdata_o == 8'h00 && !wdt_running_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs busy after reset");
    // Setting 00 stops the timer whatever the run bit
    property p_off;
        reset_n_i && config_enable_setting_i == 2'b00 |=> !wdt_running_o;
    endproperty
    a_off: assert property (p_off)
        else $error("timer runs with setting off");
    // Setting 11 runs the timer whatever the run bit
    property p_on;
        reset_n_i && config_enable_setting_i == 2'b11 |=> wdt_running_o;
    endproperty
    a_on: assert property (p_on)
        else $error("timer stopped with setting on");
    // Timeout is a single-cycle pulse
    property p_pulse;
        wdt_timeout_o |=> !wdt_timeout_o;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("timeout longer than one cycle");
    c_timeout: cover property (wdt_timeout_o);
    c_sw_run: cover property (config_enable_setting_i == 2'b01
        && wdt_running_o);
    c_reset: cover property ($rose(reset_n_i));
endmodule
bind wdpc_top wdpc_monitor wdpc_monitor_inst (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .config_enable_setting_i(config_enable_setting_i),
    .wdt_running_o(wdt_running_o), .wdt_timeout_o(wdt_timeout_o));

//--- testbench/tb.sv
/* Testbench for wdpc_top: register access, period codes, enables.
   Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
    import wdpc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] setting = 2'b01;
    logic src_tick_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [7:0] rdata_o;
    logic wdt_running_o;
    logic wdt_timeout_o;
    logic exp;
    int n_errors = 0;
    int checks = 0;
    int hit;
    // ****
    // Clock, design and bus tasks
    // ****
    always #25 sys_clk_i = ~sys_clk_i;
    wdpc_top wdpc_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .config_enable_setting_i(setting),
        .sleep_i(sleep_i), .src_tick_i(src_tick_i), .kick_i(1'b0),
        .wdt_running_o(wdt_running_o), .wdt_timeout_o(wdt_timeout_o));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(rdata_o, e)
    endtask
    // Count source ticks until the timeout pulse shows
    task automatic period(input logic [4:0] code, input int n);
        wr(WDPC_ADDR_CONTROL, {2'b00, code, 1'b1});
        hit = 0;
        for (int i = 1; i <= 2 * n && hit == 0; i++) begin
            @(posedge sys_clk_i);
            src_tick_i <= 1'b1;
            @(posedge sys_clk_i);
            src_tick_i <= 1'b0;
            repeat (3) begin
                @(negedge sys_clk_i);
                if (wdt_timeout_o === 1'b1) hit = i;
            end
        end
        `CHK(hit, n)
    endtask
    task automatic results;
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****
    // Tests and watchdog
    // ****
    initial begin
        #1_000_000;
        n_errors++;
        results;
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd(WDPC_ADDR_CONTROL, 8'h16);
        rd(4'h5, 8'h00);
        wr(WDPC_ADDR_CONTROL, 8'hFF);
        rd(WDPC_ADDR_CONTROL, 8'h3F);
        wr(4'h5, 8'h00);
        rd(WDPC_ADDR_CONTROL, 8'h3F);
        period(5'h00, 32);
        period(5'h01, 64);
        period(5'h05, 1024);
        period(5'h13, 32);
        period(5'h1F, 32);
        // Every setting against both run bit values
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 2; b++) begin
                @(posedge sys_clk_i);
                setting <= s[1:0];
                wr(WDPC_ADDR_CONTROL, {7'h00, b[0]});
                exp = (s == 1) ? b[0] : s[1];
                repeat (2) @(negedge sys_clk_i);
                `CHK(wdt_running_o, exp)
            end
        end
        // Status shows setting 11 and a running timer
        rd(WDPC_ADDR_STATUS, 8'h0D);
        // Setting 10 stops the timer while the core sleeps
        @(posedge sys_clk_i);
        setting <= 2'b10;
        sleep_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        `CHK(wdt_running_o, 1'b0)
        rd(WDPC_ADDR_STATUS, 8'h08);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd(WDPC_ADDR_CONTROL, 8'h16);
        results;
    end
endmodule
